// >>> lsir_pkg.sv
// Shared constants, field layout and helpers of the light sensor interrupt block
package lsir_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_LOW    = 4'h4;
    localparam logic [3:0] OFS_HIGH   = 4'h8;
    localparam logic [3:0] OFS_ALERT  = 4'hC;
    // Configuration field positions
    localparam int FC_LSB   = 0;
    localparam int POL_BIT  = 3;
    localparam int LAT_BIT  = 4;
    localparam int FL_BIT   = 5;
    localparam int FH_BIT   = 6;
    localparam int CR_BIT   = 7;
    localparam int MODE_LSB = 9;
    localparam int EXP_TOP_LSB = 14;
    // Reset values
    localparam logic [1:0]  RST_MODE  = 2'h0;
    localparam logic        RST_LATCH = 1'h1;
    localparam logic        RST_POL   = 1'h0;
    localparam logic [1:0]  RST_FC    = 2'h0;
    localparam logic [15:0] RST_LOW   = 16'h0000;
    localparam logic [15:0] RST_HIGH  = 16'hBFFF;
    // Encodings
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] EXP_TOP_EOC   = 2'h3;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // Merge a written word into an old one by byte strobes
    function automatic logic [31:0] lsir_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return res;
    endfunction : lsir_merge

    // Consecutive faults needed for a fault count field: 1, 2, 4 or 8
    function automatic logic [3:0] lsir_need(input logic [1:0] fc);
        return 4'h1 << fc;
    endfunction : lsir_need
endpackage : lsir_pkg

// >>> lsir_fault_counter.sv
// Consecutive fault counter for one limit
`timescale 1ns/10ps
module lsir_fault_counter #(
    parameter int CNT_W = 4
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             sample,
    input  wire logic             beyond,
    input  wire logic [CNT_W-1:0] need,
    output logic                  hit
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;

    initial begin
        if (CNT_W < 4) begin
            $error("lsir_fault_counter: CNT_W must hold a count of 8");
        end
    end

    // Next count saturates at the needed value
    always_comb begin
        count_nxt = count_r;
        if (count_r < need) begin
            count_nxt = count_r + CNT_W'(1);
        end
    end

    // Hit once the run of faults reaches the need
    assign hit = sample && beyond && (count_nxt >= need);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= '0;
        end else if (sample) begin
            count_r <= beyond ? count_nxt : '0;
        end
    end
endmodule : lsir_fault_counter

// >>> lsir_axil_slave.sv
// AXI4-Lite slave front end: handshakes, one write and one read at a time
`timescale 1ns/10ps
module lsir_axil_slave #(
    parameter int ADDR_W = 4
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axil_awaddr,
    input  wire logic              s_axil_awvalid,
    output logic                   s_axil_awready,
    input  wire logic [31:0]       s_axil_wdata,
    input  wire logic [3:0]        s_axil_wstrb,
    input  wire logic              s_axil_wvalid,
    output logic                   s_axil_wready,
    output logic [1:0]             s_axil_bresp,
    output logic                   s_axil_bvalid,
    input  wire logic              s_axil_bready,
    input  wire logic [ADDR_W-1:0] s_axil_araddr,
    input  wire logic              s_axil_arvalid,
    output logic                   s_axil_arready,
    output logic [31:0]            s_axil_rdata,
    output logic [1:0]             s_axil_rresp,
    output logic                   s_axil_rvalid,
    input  wire logic              s_axil_rready,
    output logic                   wr_en,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_err,
    output logic                   rd_en,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_err
);
    logic aw_held_r;
    logic w_held_r;

    initial begin
        if (ADDR_W < 4) begin
            $error("lsir_axil_slave: ADDR_W must cover four words");
        end
    end

    // Channels are ready while nothing is held and no answer waits
    assign s_axil_awready = !aw_held_r && !s_axil_bvalid;
    assign s_axil_wready  = !w_held_r && !s_axil_bvalid;
    assign s_axil_arready = !s_axil_rvalid;
    assign wr_en          = aw_held_r && w_held_r && !s_axil_bvalid;
    assign rd_en          = s_axil_arvalid && s_axil_arready;
    assign rd_addr        = s_axil_araddr;

    // Write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            wr_addr   <= '0;
            wr_data   <= '0;
            wr_strb   <= '0;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_held_r <= 1'b1;
                wr_addr   <= s_axil_awaddr;
            end else if (wr_en) begin
                aw_held_r <= 1'b0;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_held_r <= 1'b1;
                wr_data  <= s_axil_wdata;
                wr_strb  <= s_axil_wstrb;
            end else if (wr_en) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_bvalid <= 1'b0;
            s_axil_bresp  <= lsir_pkg::RESP_OKAY;
        end else if (wr_en) begin
            s_axil_bvalid <= 1'b1;
            s_axil_bresp  <= wr_err ? lsir_pkg::RESP_SLVERR : lsir_pkg::RESP_OKAY;
        end else if (s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
        end
    end

    // Read data captured in the cycle the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata  <= '0;
            s_axil_rresp  <= lsir_pkg::RESP_OKAY;
        end else if (rd_en) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rdata  <= rd_data;
            s_axil_rresp  <= rd_err ? lsir_pkg::RESP_SLVERR : lsir_pkg::RESP_OKAY;
        end else if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end
endmodule : lsir_axil_slave

// >>> lsir_top.sv
// Light sensor interrupt reporting: limits, fault counts, flags and interrupt pin
`timescale 1ns/10ps
// Summary of operation
// - Latch bit 1 selects latched window, 0 selects transparent hysteresis comparison.
// - Latched: flags and interrupt hold until config read; alert clears interrupt only.
// - Transparent, high run: interrupt active, flag-high 1, flag-low 0.
// - Transparent, low run: interrupt inactive outside end-of-conversion, flag-low 1, flag-high 0.
// - Transparent: config reads and writes leave flags alone, and interrupt too outside end-of-conversion.
// - Transparent: alert response is ignored and not answered.
// - A config read clears conversion-ready just after the read unless a conversion completes in the same cycle.
// - Polarity 0 pulls pin low when active; polarity 1 when inactive.
// - Low-limit exponent top bits 11 select end-of-conversion mode.
// - End-of-conversion: each conversion sets interrupt active and conversion-ready.
// - End-of-conversion latched: runs set their flag, other flag unchanged.
// - End-of-conversion latched: read, running write or alert clear interrupt.
// - End-of-conversion latched: config read clears flags, interrupt, conversion-ready.
// - Shutdown config write leaves flags and conversion-ready unchanged; interrupt too unless it clears a set latch bit.
// - Running config write clears conversion-ready, flags unchanged.
module lsir_top #(
    parameter int ADDR_W = 4,
    parameter int RES_W  = 16
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axil_awaddr,
    input  wire logic [2:0]        s_axil_awprot,
    input  wire logic              s_axil_awvalid,
    output logic                   s_axil_awready,
    input  wire logic [31:0]       s_axil_wdata,
    input  wire logic [3:0]        s_axil_wstrb,
    input  wire logic              s_axil_wvalid,
    output logic                   s_axil_wready,
    output logic [1:0]             s_axil_bresp,
    output logic                   s_axil_bvalid,
    input  wire logic              s_axil_bready,
    input  wire logic [ADDR_W-1:0] s_axil_araddr,
    input  wire logic [2:0]        s_axil_arprot,
    input  wire logic              s_axil_arvalid,
    output logic                   s_axil_arready,
    output logic [31:0]            s_axil_rdata,
    output logic [1:0]             s_axil_rresp,
    output logic                   s_axil_rvalid,
    input  wire logic              s_axil_rready,
    input  wire logic              conv_done,
    input  wire logic [RES_W-1:0]  conv_result,
    output logic                   int_o,
    output logic                   int_oe_n
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_err;
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              rd_err;
    logic [1:0]        mode_r;
    logic              latch_r;
    logic              interrupt_polarity;
    logic [1:0]        fc_r;
    logic [RES_W-1:0]  low_r;
    logic [RES_W-1:0]  high_r;
    logic              fh_r;
    logic              fl_r;
    logic              int_r;
    logic              cr_r;
    logic              fh_nxt;
    logic              fl_nxt;
    logic              int_nxt;
    logic [31:0]       cfg_word;
    logic [31:0]       cfg_new;
    logic [1:0]        low_limit_exponent_top;
    logic              eoc;
    logic              cfg_rd;
    logic              alert_rd;
    logic              cfg_wr;
    logic              run_wr;
    logic              hi_hit;
    logic              lo_hit;

    initial begin
        if (RES_W != 16) begin
            $error("lsir_top: RES_W must be 16");
        end
    end

    // ****************************************************************
    // Bus front end and decode
    // ****************************************************************
    lsir_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .s_axil_awaddr  (s_axil_awaddr),
        .s_axil_awvalid (s_axil_awvalid),
        .s_axil_awready (s_axil_awready),
        .s_axil_wdata   (s_axil_wdata),
        .s_axil_wstrb   (s_axil_wstrb),
        .s_axil_wvalid  (s_axil_wvalid),
        .s_axil_wready  (s_axil_wready),
        .s_axil_bresp   (s_axil_bresp),
        .s_axil_bvalid  (s_axil_bvalid),
        .s_axil_bready  (s_axil_bready),
        .s_axil_araddr  (s_axil_araddr),
        .s_axil_arvalid (s_axil_arvalid),
        .s_axil_arready (s_axil_arready),
        .s_axil_rdata   (s_axil_rdata),
        .s_axil_rresp   (s_axil_rresp),
        .s_axil_rvalid  (s_axil_rvalid),
        .s_axil_rready  (s_axil_rready),
        .wr_en          (wr_en),
        .wr_addr        (wr_addr),
        .wr_data        (wr_data),
        .wr_strb        (wr_strb),
        .wr_err         (wr_err),
        .rd_en          (rd_en),
        .rd_addr        (rd_addr),
        .rd_data        (rd_data),
        .rd_err         (rd_err)
    );

    // Unaligned or out-of-map addresses answer with an error
    assign wr_err   = (wr_addr[1:0] != 2'h0) || (wr_addr > ADDR_W'(lsir_pkg::OFS_ALERT));
    assign rd_err   = (rd_addr[1:0] != 2'h0) || (rd_addr > ADDR_W'(lsir_pkg::OFS_ALERT));
    assign cfg_rd   = rd_en && (rd_addr == ADDR_W'(lsir_pkg::OFS_CONFIG));
    assign alert_rd = rd_en && (rd_addr == ADDR_W'(lsir_pkg::OFS_ALERT));
    assign cfg_wr   = wr_en && (wr_addr == ADDR_W'(lsir_pkg::OFS_CONFIG));

    // Configuration word as software sees it
    always_comb begin
        cfg_word                                    = '0;
        cfg_word[lsir_pkg::FC_LSB +: 2]             = fc_r;
        cfg_word[lsir_pkg::POL_BIT]                 = interrupt_polarity;
        cfg_word[lsir_pkg::LAT_BIT]                 = latch_r;
        cfg_word[lsir_pkg::FL_BIT]                  = fl_r;
        cfg_word[lsir_pkg::FH_BIT]                  = fh_r;
        cfg_word[lsir_pkg::CR_BIT]                  = cr_r;
        cfg_word[lsir_pkg::MODE_LSB +: 2]           = mode_r;
    end

    assign cfg_new = lsir_pkg::lsir_merge(cfg_word, wr_data, wr_strb);
    assign run_wr  = cfg_wr && (cfg_new[lsir_pkg::MODE_LSB +: 2] != lsir_pkg::MODE_SHUTDOWN);

    // Read data mux; the alert word answers only in latched mode
    always_comb begin
        rd_data = '0;
        case (rd_addr)
            ADDR_W'(lsir_pkg::OFS_CONFIG): rd_data = cfg_word;
            ADDR_W'(lsir_pkg::OFS_LOW):    rd_data = {16'h0000, low_r};
            ADDR_W'(lsir_pkg::OFS_HIGH):   rd_data = {16'h0000, high_r};
            ADDR_W'(lsir_pkg::OFS_ALERT):  rd_data = {31'h00000000, latch_r && int_r};
            default:                       rd_data = '0;
        endcase
    end

    // ****************************************************************
    // Writable registers
    // ****************************************************************
    // Configuration fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r             <= lsir_pkg::RST_MODE;
            latch_r            <= lsir_pkg::RST_LATCH;
            interrupt_polarity <= lsir_pkg::RST_POL;
            fc_r               <= lsir_pkg::RST_FC;
        end else if (cfg_wr) begin
            mode_r             <= cfg_new[lsir_pkg::MODE_LSB +: 2];
            latch_r            <= cfg_new[lsir_pkg::LAT_BIT];
            interrupt_polarity <= cfg_new[lsir_pkg::POL_BIT];
            fc_r               <= cfg_new[lsir_pkg::FC_LSB +: 2];
        end
    end

    // Limit registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_r  <= lsir_pkg::RST_LOW;
            high_r <= lsir_pkg::RST_HIGH;
        end else if (wr_en) begin
            if (wr_addr == ADDR_W'(lsir_pkg::OFS_LOW)) begin
                low_r <= 16'(lsir_pkg::lsir_merge({16'h0000, low_r}, wr_data, wr_strb));
            end
            if (wr_addr == ADDR_W'(lsir_pkg::OFS_HIGH)) begin
                high_r <= 16'(lsir_pkg::lsir_merge({16'h0000, high_r}, wr_data, wr_strb));
            end
        end
    end

    assign low_limit_exponent_top = low_r[lsir_pkg::EXP_TOP_LSB +: 2];
    assign eoc = (low_limit_exponent_top == lsir_pkg::EXP_TOP_EOC);

    // ****************************************************************
    // Fault counting
    // ****************************************************************
    // separate runs per limit
    lsir_fault_counter #(.CNT_W(4)) u_hi_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sample  (conv_done),
        .beyond  (conv_result > high_r),
        .need    (lsir_pkg::lsir_need(fc_r)),
        .hit     (hi_hit)
    );

    lsir_fault_counter #(.CNT_W(4)) u_lo_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sample  (conv_done),
        .beyond  (conv_result < low_r),
        .need    (lsir_pkg::lsir_need(fc_r)),
        .hit     (lo_hit)
    );

    // ****************************************************************
    // Flags and interrupt state
    // ****************************************************************
    // Clears first, conversion events last so a set wins
    always_comb begin
        fh_nxt  = fh_r;
        fl_nxt  = fl_r;
        int_nxt = int_r;
        if (cfg_rd && latch_r) begin
            fh_nxt  = 1'b0;
            fl_nxt  = 1'b0;
            int_nxt = 1'b0;
        end
        // in end-of-conversion mode, read or running write drops the pin
        if (eoc && (cfg_rd || run_wr)) begin
            int_nxt = 1'b0;
        end
        // alert clears the pin only when latched
        if (alert_rd && latch_r) begin
            int_nxt = 1'b0;
        end
        // clearing the latch bit drops the pin
        if (cfg_wr && latch_r && !cfg_new[lsir_pkg::LAT_BIT]) begin
            int_nxt = 1'b0;
        end
        if (hi_hit) begin
            fh_nxt  = 1'b1;
            fl_nxt  = latch_r ? fl_nxt : 1'b0;
            int_nxt = 1'b1;
        end else if (lo_hit) begin
            fl_nxt  = 1'b1;
            fh_nxt  = latch_r ? fh_nxt : 1'b0;
            // transparent low run releases the pin outside end-of-conversion mode
            int_nxt = latch_r || eoc;
        end
        if (eoc && conv_done) begin
            int_nxt = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fh_r  <= 1'b0;
            fl_r  <= 1'b0;
            int_r <= 1'b0;
        end else begin
            fh_r  <= fh_nxt;
            fl_r  <= fl_nxt;
            int_r <= int_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cr_r <= 1'b0;
        end else if (conv_done) begin
            cr_r <= 1'b1;
        end else if (cfg_rd || run_wr) begin
            cr_r <= 1'b0;
        end
    end

    // open-drain pin, low when active xor polarity
    assign int_o    = 1'b0;
    assign int_oe_n = !(int_r ^ interrupt_polarity);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_read_clears_ready: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_rd && !conv_done |=> !cr_r) else $error("ready not cleared by read");
    a_trans_high_run: assert property (@(posedge aclk) disable iff (!aresetn)
        !latch_r && hi_hit |=> int_r && fh_r && !fl_r) else $error("bad transparent high");
    a_trans_low_run: assert property (@(posedge aclk) disable iff (!aresetn)
        !latch_r && !eoc && lo_hit && !hi_hit |=> !int_r && fl_r && !fh_r)
        else $error("bad transparent low");
    a_trans_stable_state: assert property (@(posedge aclk) disable iff (!aresetn)
        !latch_r && !eoc && !conv_done |=> $stable(int_r) && $stable(fh_r) && $stable(fl_r))
        else $error("transparent state moved without conversion");
    a_alert_not_answered: assert property (@(posedge aclk) disable iff (!aresetn)
        alert_rd && !latch_r |=> s_axil_rvalid && s_axil_rdata == 32'h00000000)
        else $error("alert answered in transparent mode");
    a_pin_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
        (int_r != interrupt_polarity) |-> !int_oe_n && !int_o) else $error("pin not pulled low");
    a_latched_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        latch_r && !eoc && int_r && !rd_en && !wr_en |=> int_r) else $error("latched pin dropped");
    a_eoc_conversion: assert property (@(posedge aclk) disable iff (!aresetn)
        eoc && conv_done |=> int_r && cr_r) else $error("end of conversion not reported");
    a_eoc_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        eoc && latch_r && cfg_rd && !conv_done |=> !fh_r && !fl_r && !int_r && !cr_r)
        else $error("read did not clear end-of-conversion state");
    a_shutdown_write: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_wr && !run_wr && !rd_en && !conv_done
        |=> $stable(fh_r) && $stable(fl_r) && $stable(int_r) && $stable(cr_r))
        else $error("shutdown write changed state");
endmodule : lsir_top

// >>> lsir_host_model.sv
// Host processor model issuing register bus cycles
`timescale 1ns/10ps
module lsir_host_model (
    input  wire logic aclk,
    output logic [3:0]  awaddr,
    output logic        awvalid,
    input  wire logic   awready,
    output logic [31:0] wdata,
    output logic [3:0]  wstrb,
    output logic        wvalid,
    input  wire logic   wready,
    input  wire logic   bvalid,
    output logic        bready,
    output logic [3:0]  araddr,
    output logic        arvalid,
    input  wire logic   arready,
    input  wire logic   rvalid,
    output logic        rready
);
    // ********************
    // Bus cycles
    // ********************
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hF;
    end

    // Readiness sampled mid-cycle, release after the taking edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, done;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!done);
        bready <= 1'b0;
    endtask : wr

    // Read held until answered
    task automatic rd(input logic [3:0] a);
        logic ta, done;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!done);
        rready <= 1'b0;
    endtask : rd
endmodule : lsir_host_model

// >>> tb_top.sv
// Self-checking bench of the light sensor interrupt block
`timescale 1ns/10ps
module tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        conv_done = 1'b0;
    logic [15:0] conv_result = 16'h0000;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic        int_o, int_oe_n;
    logic [33:0] exp_q[$];
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;

    lsir_host_model h (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
    lsir_top dut (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awprot(3'h0),
        .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
        .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
        .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arprot(3'h0), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready), .conv_done(conv_done), .conv_result(conv_result), .int_o(int_o),
        .int_oe_n(int_oe_n));

    // ********************
    // Helpers
    // ********************
    always #20 aclk = ~aclk;

    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        n_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk

    task automatic summarize();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        h.rd(a);
    endtask : rd

    task automatic conv(input logic [15:0] v);
        @(posedge aclk);
        conv_done <= 1'b1;
        conv_result <= v;
        @(posedge aclk);
        conv_done <= 1'b0;
        conv_result <= ~v;
    endtask : conv

    task automatic pin(input logic e);
        #1 chk({32'h0, int_o, int_oe_n}, {33'h0, e});
    endtask : pin

    // Read answers against the oldest note
    always @(negedge aclk) begin
        if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    end

    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    // Reset defaults, latched window, transparent, end-of-conversion
    initial begin
        void'($urandom(32'h18F1));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 34'h010);
        rd(4'h4, 34'h0);
        rd(4'h8, 34'hBFFF);
        rd(4'h2, 34'h2_0000_0000);
        pin(1'b1);
        h.wr(4'h4, 32'h1000);
        h.wr(4'h8, 32'h8000);
        h.wr(4'h0, 32'h210);
        repeat (3) conv(16'($urandom_range(32'h8000, 32'h1000)));
        pin(1'b1);
        rd(4'h0, 34'h290);
        rd(4'h0, 34'h210);
        conv(16'h9000);
        pin(1'b0);
        rd(4'hC, 34'h1);
        pin(1'b1);
        rd(4'h0, 34'h2D0);
        rd(4'h0, 34'h210);
        h.wr(4'h0, 32'h201);
        // Passing conversion breaks the earlier run
        conv(16'h4000);
        conv(16'h9000);
        pin(1'b1);
        conv(16'h9000);
        pin(1'b0);
        rd(4'h0, 34'h2C1);
        pin(1'b0);
        rd(4'hC, 34'h0);
        pin(1'b0);
        conv(16'h0800);
        conv(16'h0800);
        pin(1'b1);
        rd(4'h0, 34'h2A1);
        h.wr(4'h0, 32'h209);
        pin(1'b0);
        h.wr(4'h0, 32'h210);
        h.wr(4'h4, 32'hC000);
        h.wr(4'h8, 32'hF000);
        conv(16'hD000);
        pin(1'b0);
        rd(4'h0, 34'h2B0);
        pin(1'b1);
        rd(4'h0, 34'h210);
        conv(16'hD000);
        h.wr(4'h0, 32'h010);
        pin(1'b0);
        h.wr(4'h0, 32'h210);
        pin(1'b1);
        rd(4'h0, 34'h210);
        conv(16'hF800);
        pin(1'b0);
        rd(4'hC, 34'h1);
        pin(1'b1);
        rd(4'h0, 34'h2D0);
        // Leave end-of-conversion with the pin active, then drop the latch bit
        conv(16'hD000);
        h.wr(4'h4, 32'h1000);
        pin(1'b0);
        h.wr(4'h0, 32'h200);
        pin(1'b1);
        summarize();
    end
endmodule : tb_top
